// >>> dam_alarm_mgr.sv
/*
 drive alarm manager top: fault trip, alarm relay, history, retry and
 momentary power loss handling.
 assumes fault inputs are synchronous single-level events from core logic;
 the alarm reset and power-ok pins are asynchronous and synchronised here.
*/
// Operation
// - any trip halts inverter output and drives alarm relay; the power-loss stop (pwr_trip to DAM_PWR_LOST) halts output with the relay off.
// - latched alarm stop clears on digital alarm reset input, or on retry when enabled.
// - keep last four alarm codes, oldest dropped on new alarm.
// - memory error stops output and drives alarm output.
// - processor error trips with code Er3 and alarm relay.
// - tuning failure trips with code Er7 and alarm output.
// - serial link error trips with code Er8 and alarm relay.
// - data save failure under undervoltage shows ErF and relay.
// - retry auto-resets after trip; count and delay configurable.
// - power loss of 15 ms or longer stops inverter output.
// - power restored within window with restart enabled starts restart.
// - overheat or overload lowers frequency, no alarm code.
// - stall prevention acts on overcurrent, no code, no relay.
// - keypad mock request trips with code Err and relay.
// - clear-history control erases history then returns to zero.
`timescale 1ns/10ps
module dam_alarm_mgr #(
    parameter int unsigned PWR_LOSS_CYC = dam_pkg::PWR_LOSS_CYC,
    parameter int unsigned RESTART_WIN_CYC = dam_pkg::RESTART_WIN_CYC,
    parameter int unsigned RETRY_DELAY_CYC = dam_pkg::RETRY_DELAY_CYC
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire dam_pkg::dam_fault_t fault_i,
    input wire dam_pkg::dam_limit_t limit_i,
    input wire logic alarm_reset_i,
    input wire logic power_ok_i,
    input wire logic restart_en_i,
    input wire logic [3:0] retry_max_i,
    input wire logic retry_en_i,
    input wire logic clear_alarm_history_ctrl_i,
    output logic inv_run_o,
    output logic alarm_relay_o,
    output logic restart_o,
    output logic freq_reduce_o,
    output logic stall_hold_o,
    output logic clear_alarm_history_ctrl_o,
    output dam_pkg::dam_code_t alarm_code_o,
    output dam_pkg::dam_code_t hist_o [dam_pkg::HIST_DEPTH]
);
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic rst_s1_ff, rst_s2_ff, pok_s1_ff, pok_s2_ff;

    always_ff @(posedge core_clk_i) begin
        rst_s1_ff <= alarm_reset_i;
        rst_s2_ff <= rst_s1_ff;
        pok_s1_ff <= power_ok_i;
        pok_s2_ff <= pok_s1_ff;
    end

    // ----------------------------------------
    // fault decode
    // ----------------------------------------
    typedef enum logic [3:0] {
        DAM_RUN = 4'b0001,
        DAM_TRIP = 4'b0010,
        DAM_PWR_LOST = 4'b0100,
        DAM_RESTART = 4'b1000
    } dam_state_t;

    dam_state_t state_ff, nxt_state;
    logic [31:0] pwr_cnt_ff, nxt_pwr_cnt;
    logic [31:0] retry_cnt_ff, nxt_retry_cnt;
    logic [3:0] retries_ff, nxt_retries;
    dam_pkg::dam_code_t code_ff, nxt_code;
    logic clr_ff;

    function automatic dam_pkg::dam_code_t fault_code(input dam_pkg::dam_fault_t f);
        if (f.mem_err) return dam_pkg::DAM_CODE_MEM;
        if (f.cpu_err) return dam_pkg::DAM_CODE_CPU;
        if (f.tune_err) return dam_pkg::DAM_CODE_TUNE;
        if (f.comm_err) return dam_pkg::DAM_CODE_COMM;
        if (f.save_err) return dam_pkg::DAM_CODE_SAVE;
        if (f.mock_req) return dam_pkg::DAM_CODE_MOCK;
        return dam_pkg::DAM_CODE_NONE;
    endfunction

    wire logic fault_any = |fault_i;
    wire dam_pkg::dam_code_t fault_code_w = fault_code(fault_i);
    wire logic pwr_trip = (state_ff == DAM_RUN) && !pok_s2_ff && (pwr_cnt_ff >= PWR_LOSS_CYC - 1);
    wire logic new_trip = (state_ff != DAM_TRIP) && fault_any;
    wire logic retry_go = retry_en_i && (retries_ff < retry_max_i) && (retry_cnt_ff >= RETRY_DELAY_CYC - 1);
    wire logic trip_clear = rst_s2_ff || retry_go;

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_code = code_ff;
        nxt_pwr_cnt = 32'h0000_0000;
        nxt_retry_cnt = 32'h0000_0000;
        nxt_retries = retries_ff;
        unique case (state_ff)
            DAM_RUN: begin
                if (fault_any) begin
                    nxt_state = DAM_TRIP;
                    nxt_code = fault_code_w;
                end else if (pwr_trip) begin
                    nxt_state = DAM_PWR_LOST;
                end else if (!pok_s2_ff) begin
                    nxt_pwr_cnt = pwr_cnt_ff + 32'h0000_0001;
                end
            end
            DAM_TRIP: begin
                nxt_retry_cnt = retry_cnt_ff + 32'h0000_0001;
                if (rst_s2_ff) begin
                    nxt_state = DAM_RUN;
                    nxt_code = dam_pkg::DAM_CODE_NONE;
                    nxt_retries = 4'h0;
                end else if (retry_go) begin
                    nxt_state = DAM_RESTART;
                    nxt_code = dam_pkg::DAM_CODE_NONE;
                    nxt_retries = retries_ff + 4'h1;
                end
            end
            DAM_PWR_LOST: begin
                if (fault_any) begin
                    nxt_state = DAM_TRIP;
                    nxt_code = fault_code_w;
                end else if (pok_s2_ff) begin
                    if (restart_en_i && pwr_cnt_ff < RESTART_WIN_CYC)
                        nxt_state = DAM_RESTART;
                    else begin
                        nxt_state = DAM_TRIP;
                        nxt_code = dam_pkg::DAM_CODE_PWR;
                    end
                end else begin
                    nxt_pwr_cnt = pwr_cnt_ff + 32'h0000_0001;
                end
            end
            DAM_RESTART: begin
                if (fault_any) begin
                    nxt_state = DAM_TRIP;
                    nxt_code = fault_code_w;
                end else begin
                    nxt_state = DAM_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_ff <= DAM_RUN;
            code_ff <= dam_pkg::DAM_CODE_NONE;
            pwr_cnt_ff <= 32'h0000_0000;
            retry_cnt_ff <= 32'h0000_0000;
            retries_ff <= 4'h0;
            clr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            code_ff <= nxt_code;
            pwr_cnt_ff <= nxt_pwr_cnt;
            retry_cnt_ff <= nxt_retry_cnt;
            retries_ff <= nxt_retries;
            clr_ff <= clear_alarm_history_ctrl_i;
        end
    end

    // ----------------------------------------
    // history and outputs
    // ----------------------------------------
    wire logic hist_push = (state_ff != DAM_TRIP) && (nxt_state == DAM_TRIP);

    dam_history #(
        .DEPTH(dam_pkg::HIST_DEPTH)
    ) u_hist (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .push_i(hist_push),
        .code_i(nxt_code),
        .clear_i(clr_ff),
        .hist_o(hist_o)
    );

    assign inv_run_o = (state_ff == DAM_RUN);
    assign alarm_relay_o = (state_ff == DAM_TRIP);
    assign restart_o = (state_ff == DAM_RESTART);
    assign alarm_code_o = code_ff;
    assign freq_reduce_o = limit_i.heatsink_overheat_alarm || limit_i.inverter_overload_alarm;
    assign stall_hold_o = limit_i.stall_overcurrent;
    // readback is the control input one cycle late; it stays high while the input is held and falls one cycle after the input falls
    assign clear_alarm_history_ctrl_o = clr_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence fault_seen;
        (state_ff == DAM_RUN) && fault_any;
    endsequence

    trip_relay_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        fault_seen |=> alarm_relay_o && !inv_run_o) else $error("trip did not assert relay");
    any_trip_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        new_trip |=> alarm_relay_o && !inv_run_o) else $error("fault outside run did not trip");
    trip_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        alarm_relay_o && !trip_clear |=> alarm_relay_o) else $error("trip released early");
    cpu_code_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i == 6'b010000) |=> alarm_code_o == dam_pkg::DAM_CODE_CPU)
        else $error("cpu code wrong");
    mem_stop_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i.mem_err) |=> alarm_code_o == dam_pkg::DAM_CODE_MEM && !inv_run_o)
        else $error("memory error not handled");
    tune_code_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i == 6'b001000) |=> alarm_code_o == dam_pkg::DAM_CODE_TUNE)
        else $error("tune code wrong");
    comm_code_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i == 6'b000100) |=> alarm_code_o == dam_pkg::DAM_CODE_COMM)
        else $error("comm code wrong");
    save_code_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i == 6'b000010) |=> alarm_code_o == dam_pkg::DAM_CODE_SAVE)
        else $error("save code wrong");
    mock_code_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (fault_seen and fault_i == 6'b000001) |=> alarm_code_o == dam_pkg::DAM_CODE_MOCK && alarm_relay_o)
        else $error("mock alarm wrong");
    pwr_stop_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pwr_trip && !fault_any |=> !inv_run_o && !alarm_relay_o) else $error("power loss not stopped");
    reset_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        alarm_relay_o && rst_s2_ff |=> alarm_code_o == dam_pkg::DAM_CODE_NONE && inv_run_o)
        else $error("alarm reset failed");
    limit_quiet_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        inv_run_o && !fault_any && !pwr_trip && stall_hold_o |=> !alarm_relay_o)
        else $error("stall raised alarm");
endmodule

// >>> dam_pkg.sv
/*
 drive alarm manager package: alarm codes, carriers, timing constants.
 assumes a 40 MHz core clock.
*/
package dam_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned PWR_LOSS_MS = 15;
    localparam int unsigned PWR_LOSS_CYC = (CLK_HZ / 1000) * PWR_LOSS_MS;
    localparam int unsigned RESTART_WIN_MS = 500;
    localparam int unsigned RESTART_WIN_CYC = (CLK_HZ / 1000) * RESTART_WIN_MS;
    localparam int unsigned RETRY_DELAY_MS = 100;
    localparam int unsigned RETRY_DELAY_CYC = (CLK_HZ / 1000) * RETRY_DELAY_MS;
    localparam int unsigned HIST_DEPTH = 4;
    localparam logic [3:0] RETRY_MAX_RST = 4'h3;

    typedef enum logic [3:0] {
        DAM_CODE_NONE = 4'h0,
        DAM_CODE_MEM = 4'h1,
        DAM_CODE_CPU = 4'h3,
        DAM_CODE_TUNE = 4'h7,
        DAM_CODE_COMM = 4'h8,
        DAM_CODE_SAVE = 4'hF,
        DAM_CODE_MOCK = 4'hE,
        DAM_CODE_PWR = 4'h2
    } dam_code_t;

    typedef struct packed {
        logic mem_err;
        logic cpu_err;
        logic tune_err;
        logic comm_err;
        logic save_err;
        logic mock_req;
    } dam_fault_t;

    typedef struct packed {
        logic heatsink_overheat_alarm;
        logic inverter_overload_alarm;
        logic stall_overcurrent;
    } dam_limit_t;
endpackage

// >>> dam_history.sv
/*
 alarm history shift store, newest entry at index 0.
 assumes push and clear come from the same clock domain.
*/
`timescale 1ns/10ps
module dam_history #(
    parameter int DEPTH = 4
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire dam_pkg::dam_code_t code_i,
    input wire logic clear_i,
    output dam_pkg::dam_code_t hist_o [DEPTH]
);
    dam_pkg::dam_code_t hist_ff [DEPTH];

    always_ff @(posedge core_clk_i) begin
        if (srst_i || clear_i) begin
            for (int i = 0; i < DEPTH; i++) hist_ff[i] <= dam_pkg::DAM_CODE_NONE;
        end else if (push_i) begin
            hist_ff[0] <= code_i;
            for (int i = 1; i < DEPTH; i++) hist_ff[i] <= hist_ff[i-1];
        end
    end

    assign hist_o = hist_ff;

    hist_push_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
        push_i && !clear_i |=> hist_ff[0] == $past(code_i) && hist_ff[1] == $past(hist_ff[0]))
        else $error("history did not shift on push");
endmodule

// >>> dam_far_end.sv
/*
 far-end model: alarm reset pin of the control terminal and mains sense.
 assumes commands from the bench arrive one cycle wide on the core clock.
*/
`timescale 1ns/10ps
module dam_far_end (
    input wire logic core_clk_i,
    input wire logic reset_go_i,
    input wire logic drop_go_i,
    input wire logic [7:0] drop_len_i,
    output logic alarm_reset_o,
    output logic power_ok_o
);
    logic [2:0] rst_cnt_ff = 3'h0;
    logic [7:0] drop_cnt_ff = 8'h00;
    // pin held several cycles so the two-flop sync sees it
    always @(posedge core_clk_i) begin
        if (reset_go_i) rst_cnt_ff <= 3'h4;
        else if (rst_cnt_ff != 3'h0) rst_cnt_ff <= rst_cnt_ff - 3'h1;
        if (drop_go_i) drop_cnt_ff <= drop_len_i;
        else if (drop_cnt_ff != 8'h00) drop_cnt_ff <= drop_cnt_ff - 8'h01;
    end
    assign alarm_reset_o = (rst_cnt_ff != 3'h0);
    assign power_ok_o = (drop_cnt_ff == 8'h00);
endmodule

// >>> drive_alarm_manager_test.sv
/*
 self-checking bench for the alarm manager, run with small timing counts.
 assumes the far-end model drives the reset pin and the mains sense.
*/
`timescale 1ns/10ps
module drive_alarm_manager_test;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    dam_pkg::dam_fault_t fault_i = '0;
    dam_pkg::dam_limit_t limit_i = '0;
    logic restart_en_i = 1'b0, retry_en_i = 1'b0, clr_i = 1'b0, rst_go = 1'b0, drop_go = 1'b0;
    logic [3:0] retry_max_i = 4'h0;
    logic [7:0] drop_len = 8'h28;
    logic alarm_reset, power_ok, inv_run, relay, restart, freq_red, stall, clr_o;
    dam_pkg::dam_code_t code;
    dam_pkg::dam_code_t hist [dam_pkg::HIST_DEPTH];
    logic [3:0] eh [4];
    int num_errors = 0, checks = 0, n;

    dam_alarm_mgr #(.PWR_LOSS_CYC(20), .RESTART_WIN_CYC(100), .RETRY_DELAY_CYC(10)) DUT (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .fault_i(fault_i), .limit_i(limit_i),
        .alarm_reset_i(alarm_reset), .power_ok_i(power_ok), .restart_en_i(restart_en_i),
        .retry_max_i(retry_max_i), .retry_en_i(retry_en_i), .clear_alarm_history_ctrl_i(clr_i),
        .inv_run_o(inv_run), .alarm_relay_o(relay), .restart_o(restart), .freq_reduce_o(freq_red),
        .stall_hold_o(stall), .clear_alarm_history_ctrl_o(clr_o), .alarm_code_o(code), .hist_o(hist));
    dam_far_end far (.core_clk_i(core_clk_i), .reset_go_i(rst_go), .drop_go_i(drop_go),
        .drop_len_i(drop_len), .alarm_reset_o(alarm_reset), .power_ok_o(power_ok));

    initial forever #12.5 core_clk_i = ~core_clk_i;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] prio(input dam_pkg::dam_fault_t f);
        if (f.mem_err) return dam_pkg::DAM_CODE_MEM;
        if (f.cpu_err) return dam_pkg::DAM_CODE_CPU;
        if (f.tune_err) return dam_pkg::DAM_CODE_TUNE;
        if (f.comm_err) return dam_pkg::DAM_CODE_COMM;
        if (f.save_err) return dam_pkg::DAM_CODE_SAVE;
        return dam_pkg::DAM_CODE_MOCK;
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int c);
        repeat (c) @(posedge core_clk_i);
        #1;
    endtask
    task automatic push(input logic [3:0] c);
        for (int i = 3; i > 0; i--) eh[i] = eh[i-1];
        eh[0] = c;
    endtask
    task automatic pin_reset;
        @(posedge core_clk_i) rst_go <= 1'b1;
        @(posedge core_clk_i) rst_go <= 1'b0;
        step(8);
        chk(relay, 1'b0);
        chk(inv_run, 1'b1);
        chk(code, dam_pkg::DAM_CODE_NONE);
    endtask
    task automatic trip(input dam_pkg::dam_fault_t f);
        @(posedge core_clk_i) fault_i <= f;
        @(posedge core_clk_i) fault_i <= '0;
        #1;
        push(prio(f));
        chk(relay, 1'b1);
        chk(inv_run, 1'b0);
        chk(code, eh[0]);
        for (int i = 0; i < 4; i++) chk(hist[i], eh[i]);
    endtask
    task automatic drop;
        @(posedge core_clk_i) drop_go <= 1'b1;
        @(posedge core_clk_i) drop_go <= 1'b0;
        step(36);
        chk(inv_run, 1'b0);
    endtask
    task finish_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        #750000;
        num_errors++;
        finish_test;
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        dam_pkg::dam_fault_t f;
        void'($urandom(32'h41d62378));
        eh = '{default: 4'h0};
        repeat (2) @(posedge core_clk_i);
        srst_i <= 1'b0;
        step(3);
        chk(code, dam_pkg::DAM_CODE_NONE);
        for (n = 0; n < 14; n++) begin
            f = (n < 6) ? dam_pkg::dam_fault_t'(6'h20 >> n) : dam_pkg::dam_fault_t'(6'($urandom_range(63, 1)));
            trip(f);
            @(posedge core_clk_i) fault_i <= dam_pkg::dam_fault_t'(6'h3F);
            @(posedge core_clk_i) fault_i <= '0;
            step(1);
            chk(code, eh[0]);
            chk(hist[1], eh[1]);
            pin_reset;
            @(posedge core_clk_i) limit_i <= dam_pkg::dam_limit_t'(3'($urandom_range(7, 0)));
            #1;
            chk(freq_red, limit_i.heatsink_overheat_alarm | limit_i.inverter_overload_alarm);
            chk(stall, limit_i.stall_overcurrent);
            step(1);
            chk(relay, 1'b0);
            chk(code, dam_pkg::DAM_CODE_NONE);
        end
        @(posedge core_clk_i) clr_i <= 1'b1;
        @(posedge core_clk_i) clr_i <= 1'b0;
        #1;
        chk(clr_o, 1'b1);
        step(1);
        eh = '{default: 4'h0};
        for (int i = 0; i < 4; i++) chk(hist[i], 4'h0);
        chk(clr_o, 1'b0);
        @(posedge core_clk_i) restart_en_i <= 1'b1;
        drop;
        chk(relay, 1'b0);
        for (n = 0; n < 60 && restart !== 1'b1; n++) step(1);
        chk(restart, 1'b1);
        step(1);
        chk(inv_run, 1'b1);
        @(posedge core_clk_i) restart_en_i <= 1'b0;
        drop;
        for (n = 0; n < 60 && relay !== 1'b1; n++) step(1);
        push(dam_pkg::DAM_CODE_PWR);
        chk(code, dam_pkg::DAM_CODE_PWR);
        pin_reset;
        // restart enabled but mains back after the window: trips instead
        @(posedge core_clk_i) restart_en_i <= 1'b1;
        drop_len <= 8'hC8;
        drop;
        for (n = 0; n < 200 && relay !== 1'b1; n++) step(1);
        push(dam_pkg::DAM_CODE_PWR);
        chk(code, dam_pkg::DAM_CODE_PWR);
        chk(hist[1], eh[1]);
        @(posedge core_clk_i) restart_en_i <= 1'b0;
        pin_reset;
        @(posedge core_clk_i) retry_max_i <= 4'h1;
        retry_en_i <= 1'b1;
        trip(dam_pkg::dam_fault_t'(6'h10));
        for (n = 0; n < 40 && restart !== 1'b1; n++) step(1);
        chk(restart, 1'b1);
        step(1);
        chk(inv_run, 1'b1);
        trip(dam_pkg::dam_fault_t'(6'h04));
        step(30);
        chk(relay, 1'b1);
        @(posedge core_clk_i) retry_en_i <= 1'b0;
        pin_reset;
        finish_test;
    end
endmodule
